// >>> src/spi_regs_pkg.sv
package spi_regs_pkg;

    // Register addresses, 7-bit field of the command word.
    localparam logic [6:0] ADDR_SW = 7'h01;
    localparam logic [6:0] ADDR_CFG = 7'h02;
    localparam logic [6:0] ADDR_FLAGS = 7'h03;
    localparam logic [6:0] ADDR_BURST = 7'h05;
    localparam logic [6:0] ADDR_KEY = 7'h0B;

    // Reset values.
    localparam logic [7:0] RST_SW = 8'h00;
    localparam logic [7:0] RST_CFG = 8'h06;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_BURST = 8'h00;

    // Writable bits of the switch, config and burst registers.
    localparam logic [7:0] MASK_SW = 8'h0F;
    localparam logic [7:0] MASK_CFG = 8'h07;
    localparam logic [7:0] MASK_BURST = 8'h01;

    // Bit positions, shared by the flag and the check-enable registers; BIT_BURST is in the burst register.
    localparam int BIT_CRC = 0;
    localparam int BIT_CLK = 1;
    localparam int BIT_RW = 2;
    localparam int BIT_BURST = 0;

    // Command word layout: read flag, address, data.
    localparam int CMD_READ_BIT = 15;
    localparam logic [15:0] CLEAR_CMD = 16'h6CA9;
    localparam logic [7:0] KEY_FIRST = 8'hA3;
    localparam logic [7:0] KEY_SECOND = 8'h05;

    // Frame lengths in serial clocks.
    localparam int FRAME_BITS = 16;
    localparam int CRC_BITS = 8;
    localparam int FRAME_CRC_BITS = FRAME_BITS + CRC_BITS;
    localparam int ADDR_DONE_BIT = 7;

    // Checksum: polynomial x^8+x^2+x+1, seed zero, command word MSB first.
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // Timing of the host end.
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCLK_HALF_NS = 160;
    localparam int CS_GAP_NS = 200;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CS_GAP_CYC = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic din);
        crc8_step = {crc[6:0], 1'b0} ^ ((crc[7] ^ din) ? CRC_POLY : 8'h00);
    endfunction

    function automatic logic [7:0] crc8_word(input logic [15:0] word);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = crc8_step(c, word[i]);
        end
        crc8_word = c;
    endfunction

endpackage

// >>> src/spi_link_if.sv
`timescale 1ns/1ps
interface spi_link_if;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic sdo;

    modport dev (input cs_n, input sclk, input sdi, output sdo);
    modport host (output cs_n, output sclk, output sdi, input sdo);
endinterface

// >>> src/spi_reg_dev.sv
`timescale 1ns/1ps
module spi_reg_dev (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Serial link.
    spi_link_if.dev link,
    // Register state seen by the rest of the chip.
    output logic [3:0] sw_en,
    output logic [7:0] flag_state,
    output logic burst_active
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: {cs_n, sclk, sdi}.

    logic [2:0] s1_r, s2_r, s3_r, filt_r, prev_r;
    logic [2:0] filt_nxt;

    // A change is believed only once the second and third stages agree.
    always_comb begin
        filt_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s1_r <= 3'h4;
            s2_r <= 3'h4;
            s3_r <= 3'h4;
            filt_r <= 3'h4;
            prev_r <= 3'h4;
        end else begin
            s1_r <= {link.cs_n, link.sclk, link.sdi};
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= filt_nxt;
            prev_r <= filt_r;
        end
    end

    logic cs_fall, cs_rise, sck_rise, sck_fall;
    assign cs_fall = prev_r[2] & ~filt_r[2];
    assign cs_rise = ~prev_r[2] & filt_r[2];
    assign sck_rise = ~filt_r[2] & ~prev_r[1] & filt_r[1];
    assign sck_fall = ~filt_r[2] & prev_r[1] & ~filt_r[1];

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.

    logic [7:0] sw_r, cfg_r, flags_r, burst_r;

    function automatic logic readable(input logic [6:0] a);
        readable = (a == spi_regs_pkg::ADDR_SW) || (a == spi_regs_pkg::ADDR_CFG) ||
                   (a == spi_regs_pkg::ADDR_FLAGS) || (a == spi_regs_pkg::ADDR_BURST) ||
                   (a == spi_regs_pkg::ADDR_KEY);
    endfunction

    function automatic logic writable(input logic [6:0] a);
        writable = readable(a) && (a != spi_regs_pkg::ADDR_FLAGS);
    endfunction

    function automatic logic [7:0] read_value(input logic [6:0] a);
        case (a)
            spi_regs_pkg::ADDR_SW: read_value = sw_r;
            spi_regs_pkg::ADDR_CFG: read_value = cfg_r;
            spi_regs_pkg::ADDR_FLAGS: read_value = flags_r;
            spi_regs_pkg::ADDR_BURST: read_value = burst_r;
            default: read_value = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Frame receiver.

    logic crc_en, burst_on;
    assign crc_en = cfg_r[spi_regs_pkg::BIT_CRC];
    assign burst_on = burst_r[spi_regs_pkg::BIT_BURST];

    logic [23:0] shift_r, shift_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [4:0] len;
    logic done_r, done_nxt, over_r, over_nxt;
    logic [7:0] crc_r, crc_nxt, tx_r, tx_nxt;
    logic [15:0] cmd_r, cmd_nxt;
    logic crc_ok_r, crc_ok_nxt, go_r, go_nxt, cnt_err_r, cnt_err_nxt;
    logic sdo_r, sdo_nxt;
    logic whole;

    assign len = crc_en ? 5'(spi_regs_pkg::FRAME_CRC_BITS) : 5'(spi_regs_pkg::FRAME_BITS);
    // Whole commands only: at least one, none cut short, none spilling over.
    assign whole = done_r && !over_r && (cnt_r == 5'h00);

    always_comb begin
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        done_nxt = done_r;
        over_nxt = over_r;
        crc_nxt = crc_r;
        tx_nxt = tx_r;
        cmd_nxt = cmd_r;
        crc_ok_nxt = crc_ok_r;
        sdo_nxt = sdo_r;
        go_nxt = 1'b0;
        cnt_err_nxt = 1'b0;
        if (cs_fall) begin
            cnt_nxt = 5'h00;
            done_nxt = 1'b0;
            over_nxt = 1'b0;
            crc_nxt = spi_regs_pkg::CRC_INIT;
            tx_nxt = 8'h00;
            sdo_nxt = 1'b0;
        end else if (sck_rise) begin
            shift_nxt = {shift_r[22:0], filt_r[0]};
            if (done_r && !burst_on) begin
                over_nxt = 1'b1;
            end else begin
                if (cnt_r < 5'(spi_regs_pkg::FRAME_BITS)) begin
                    crc_nxt = spi_regs_pkg::crc8_step(crc_r, filt_r[0]);
                end
                if (cnt_r == 5'(spi_regs_pkg::ADDR_DONE_BIT) &&
                    shift_nxt[spi_regs_pkg::ADDR_DONE_BIT]) begin
                    tx_nxt = read_value(shift_nxt[6:0]);
                end
                if (cnt_r == len - 5'h01) begin
                    cnt_nxt = 5'h00;
                    done_nxt = 1'b1;
                    cmd_nxt = crc_en ? shift_nxt[23:8] : shift_nxt[15:0];
                    crc_ok_nxt = !crc_en || (shift_nxt[7:0] == crc_r);
                    crc_nxt = spi_regs_pkg::CRC_INIT;
                    go_nxt = burst_on;
                end else begin
                    cnt_nxt = cnt_r + 5'h01;
                end
            end
        end else if (sck_fall) begin
            sdo_nxt = tx_r[7];
            tx_nxt = {tx_r[6:0], 1'b0};
        end
        if (cs_rise) begin
            go_nxt = !burst_on && whole;
            cnt_err_nxt = !whole;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            shift_r <= 24'h000000;
            cnt_r <= 5'h00;
            done_r <= 1'b0;
            over_r <= 1'b0;
            crc_r <= spi_regs_pkg::CRC_INIT;
            tx_r <= 8'h00;
            cmd_r <= 16'h0000;
            crc_ok_r <= 1'b0;
            go_r <= 1'b0;
            cnt_err_r <= 1'b0;
            sdo_r <= 1'b0;
        end else begin
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
            over_r <= over_nxt;
            crc_r <= crc_nxt;
            tx_r <= tx_nxt;
            cmd_r <= cmd_nxt;
            crc_ok_r <= crc_ok_nxt;
            go_r <= go_nxt;
            cnt_err_r <= cnt_err_nxt;
            sdo_r <= sdo_nxt;
        end
    end

    assign link.sdo = sdo_r;

    ////////////////////////////////////////////////////////////////////////////
    // Register bank and command execution.

    logic [7:0] sw_nxt, cfg_nxt, flags_nxt, burst_nxt, set_bits;
    logic pend_r, pend_nxt, clr;
    logic [6:0] addr;
    logic [7:0] data;
    assign addr = cmd_r[14:8];
    assign data = cmd_r[7:0];

    always_comb begin
        sw_nxt = sw_r;
        cfg_nxt = cfg_r;
        burst_nxt = burst_r;
        pend_nxt = pend_r;
        set_bits = 8'h00;
        clr = 1'b0;
        set_bits[spi_regs_pkg::BIT_CLK] = cnt_err_r && cfg_r[spi_regs_pkg::BIT_CLK];
        if (go_r) begin
            if (!crc_ok_r) begin
                // A bad checksum discards the command, the clear included.
                set_bits[spi_regs_pkg::BIT_CRC] = !cmd_r[spi_regs_pkg::CMD_READ_BIT];
            end else if (cmd_r == spi_regs_pkg::CLEAR_CMD) begin
                clr = 1'b1;
            end else if (cmd_r[spi_regs_pkg::CMD_READ_BIT]) begin
                set_bits[spi_regs_pkg::BIT_RW] = !readable(addr) && cfg_r[spi_regs_pkg::BIT_RW];
            end else begin
                pend_nxt = (addr == spi_regs_pkg::ADDR_KEY) && (data == spi_regs_pkg::KEY_FIRST);
                set_bits[spi_regs_pkg::BIT_RW] = !writable(addr) && cfg_r[spi_regs_pkg::BIT_RW];
                case (addr)
                    spi_regs_pkg::ADDR_SW: sw_nxt = data & spi_regs_pkg::MASK_SW;
                    spi_regs_pkg::ADDR_CFG: cfg_nxt = data & spi_regs_pkg::MASK_CFG;
                    spi_regs_pkg::ADDR_BURST: burst_nxt = data & spi_regs_pkg::MASK_BURST;
                    default: ;
                endcase
            end
        end
        // A new event outweighs a clear in the same cycle; bits 7:3 never set.
        flags_nxt = (clr ? spi_regs_pkg::RST_FLAGS : flags_r) | set_bits;
        if (go_r && crc_ok_r && !cmd_r[spi_regs_pkg::CMD_READ_BIT] && pend_r &&
            addr == spi_regs_pkg::ADDR_KEY && data == spi_regs_pkg::KEY_SECOND) begin
            sw_nxt = spi_regs_pkg::RST_SW;
            cfg_nxt = spi_regs_pkg::RST_CFG;
            flags_nxt = spi_regs_pkg::RST_FLAGS;
            burst_nxt = spi_regs_pkg::RST_BURST;
            pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sw_r <= spi_regs_pkg::RST_SW;
            cfg_r <= spi_regs_pkg::RST_CFG;
            flags_r <= spi_regs_pkg::RST_FLAGS;
            burst_r <= spi_regs_pkg::RST_BURST;
            pend_r <= 1'b0;
        end else begin
            sw_r <= sw_nxt;
            cfg_r <= cfg_nxt;
            flags_r <= flags_nxt;
            burst_r <= burst_nxt;
            pend_r <= pend_nxt;
        end
    end

    assign sw_en = sw_r[3:0];
    assign flag_state = flags_r;
    assign burst_active = burst_r[spi_regs_pkg::BIT_BURST];

endmodule // spi_reg_dev

// >>> src/spi_reg_host.sv
`timescale 1ns/1ps
module spi_reg_host #(
    parameter int HALF_CYC = spi_regs_pkg::SCLK_HALF_CYC,
    parameter int GAP_CYC = spi_regs_pkg::CS_GAP_CYC
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Serial link.
    spi_link_if.host link,
    // Command request.
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_word,
    input wire logic crc_on,
    input wire logic keep_cs,
    output logic cmd_ready,
    // Answer.
    output logic rsp_valid,
    output logic [7:0] rsp_data
);

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_HOLD = 4'b0010,
        ST_SHIFT = 4'b0100,
        ST_GAP = 4'b1000
    } host_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Return data synchroniser.

    logic s1_r, s2_r, s3_r, sdo_f_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            sdo_f_r <= 1'b0;
        end else begin
            s1_r <= link.sdo;
            s2_r <= s1_r;
            s3_r <= s2_r;
            sdo_f_r <= (s2_r == s3_r) ? s3_r : sdo_f_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame sequencer. The half period must cover the device's synchroniser
    // delay twice over, or read data arrives after the sampling edge.

    host_state_t state_r, state_nxt;
    logic cs_n_r, cs_n_nxt, sclk_r, sclk_nxt, sdi_r, sdi_nxt;
    logic [23:0] out_r, out_nxt;
    logic [7:0] rx_r, rx_nxt, rsp_r, rsp_nxt;
    logic [4:0] bits_r, bits_nxt, len_r, len_nxt;
    logic [7:0] ph_r, ph_nxt;
    logic keep_r, keep_nxt, ready_r, ready_nxt, rv_r, rv_nxt;

    always_comb begin
        state_nxt = state_r;
        cs_n_nxt = cs_n_r;
        sclk_nxt = sclk_r;
        sdi_nxt = sdi_r;
        out_nxt = out_r;
        rx_nxt = rx_r;
        rsp_nxt = rsp_r;
        bits_nxt = bits_r;
        len_nxt = len_r;
        ph_nxt = ph_r;
        keep_nxt = keep_r;
        ready_nxt = ready_r;
        rv_nxt = 1'b0;
        case (state_r)
            ST_IDLE, ST_HOLD: begin
                if (cmd_valid && ready_r) begin
                    // The checksum byte is appended only when checking is on.
                    out_nxt = {cmd_word, crc_on ? spi_regs_pkg::crc8_word(cmd_word) : 8'h00};
                    len_nxt = crc_on ? 5'(spi_regs_pkg::FRAME_CRC_BITS)
                                     : 5'(spi_regs_pkg::FRAME_BITS);
                    bits_nxt = 5'h00;
                    ph_nxt = 8'h00;
                    cs_n_nxt = 1'b0;
                    sdi_nxt = cmd_word[15];
                    keep_nxt = keep_cs;
                    ready_nxt = 1'b0;
                    state_nxt = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                ph_nxt = ph_r + 8'h01;
                if (ph_r == 8'(HALF_CYC - 1)) begin
                    ph_nxt = 8'h00;
                    if (!sclk_r) begin
                        sclk_nxt = 1'b1;
                        if (bits_r >= 5'd8 && bits_r < 5'(spi_regs_pkg::FRAME_BITS)) begin
                            rx_nxt = {rx_r[6:0], sdo_f_r};
                        end
                    end else begin
                        sclk_nxt = 1'b0;
                        out_nxt = {out_r[22:0], 1'b0};
                        sdi_nxt = out_r[22];
                        bits_nxt = bits_r + 5'h01;
                        if (bits_r == len_r - 5'h01) begin
                            rv_nxt = 1'b1;
                            rsp_nxt = rx_r;
                            sdi_nxt = 1'b0;
                            if (keep_r) begin
                                ready_nxt = 1'b1;
                                state_nxt = ST_HOLD;
                            end else begin
                                cs_n_nxt = 1'b1;
                                state_nxt = ST_GAP;
                            end
                        end
                    end
                end
            end
            ST_GAP: begin
                ph_nxt = ph_r + 8'h01;
                if (ph_r == 8'(GAP_CYC - 1)) begin
                    ph_nxt = 8'h00;
                    ready_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                cs_n_nxt = 1'b1;
                sclk_nxt = 1'b0;
                ready_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cs_n_r <= 1'b1;
            sclk_r <= 1'b0;
            sdi_r <= 1'b0;
            out_r <= 24'h000000;
            rx_r <= 8'h00;
            rsp_r <= 8'h00;
            bits_r <= 5'h00;
            len_r <= 5'h00;
            ph_r <= 8'h00;
            keep_r <= 1'b0;
            ready_r <= 1'b1;
            rv_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cs_n_r <= cs_n_nxt;
            sclk_r <= sclk_nxt;
            sdi_r <= sdi_nxt;
            out_r <= out_nxt;
            rx_r <= rx_nxt;
            rsp_r <= rsp_nxt;
            bits_r <= bits_nxt;
            len_r <= len_nxt;
            ph_r <= ph_nxt;
            keep_r <= keep_nxt;
            ready_r <= ready_nxt;
            rv_r <= rv_nxt;
        end
    end

    assign link.cs_n = cs_n_r;
    assign link.sclk = sclk_r;
    assign link.sdi = sdi_r;
    assign cmd_ready = ready_r;
    assign rsp_valid = rv_r;
    assign rsp_data = rsp_r;

endmodule // spi_reg_host

// >>> bench/spi_error_burst_reset_regs_monitor.sv
`timescale 1ns/1ps
module spi_error_burst_reset_regs_monitor (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Serial link and register state.
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic [7:0] flag_state,
    input wire logic burst_active
);
    logic sclk_r;
    logic [7:0] cnt_r;
    logic [7:0] idle_r;
    logic [15:0] word_r;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Clocks per select and the last sixteen bits seen, judged when select rises.
    always_ff @(posedge sys_clk) begin
        sclk_r <= sclk;
        if (!rst_n || cs_n) begin
            cnt_r <= 8'h00;
        end else if (sclk && !sclk_r) begin
            cnt_r <= cnt_r + 8'h01;
            word_r <= {word_r[14:0], sdi};
        end
        if (!rst_n || !cs_n) begin
            idle_r <= 8'h00;
        end else if (idle_r != 8'hFF) begin
            idle_r <= idle_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    AST_FLAG_UPPER: assert property (flag_state[7:3] == 5'h00)
        else $error("flag bits 7 to 3 not zero");
    AST_RESET_VALUES: assert property ($rose(rst_n)
        |-> flag_state == 8'h00 && !burst_active)
        else $error("register state not cleared by reset");
    // A quiet link must not move the flags or the burst bit; effects land a few cycles after select rises.
    AST_IDLE_STABLE: assert property (idle_r >= 8'h10
        |-> $stable(flag_state) && $stable(burst_active))
        else $error("register state changed on an idle link");
    AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
        else $error("serial clock high outside a frame");
    AST_CS_LEAD: assert property ($fell(cs_n) |-> !sclk [*8])
        else $error("serial clock rose too soon after select");
    // The high phase is the host's default half period of sixteen cycles.
    AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*8] ##1 sclk [*8] ##1 !sclk)
        else $error("serial clock high phase wrong length");
    AST_SDI_HOLD: assert property (sclk && $past(sclk) |-> $stable(sdi))
        else $error("data changed while serial clock high");
    AST_CLK_COUNT: assert property ($rose(cs_n) && !burst_active
        && cnt_r != 8'h10 && cnt_r != 8'h18 |-> ##[1:12] flag_state[1])
        else $error("clock count error not flagged");
    AST_CLEAR: assert property ($rose(cs_n) && cnt_r == 8'h10
        && word_r == spi_regs_pkg::CLEAR_CMD |-> ##12 (flag_state == 8'h00 || flag_state[1]))
        else $error("clear command did not clear the flags");

    COV_CLEAR: cover property ($rose(cs_n) && word_r == spi_regs_pkg::CLEAR_CMD);
    COV_CLK_ERR: cover property ($rose(flag_state[1]));
    COV_BURST: cover property (burst_active && $rose(cs_n) && cnt_r == 8'h20);
endmodule // spi_error_burst_reset_regs_monitor

// >>> bench/spi_error_burst_reset_regs_tb.sv
`timescale 1ns/1ps
module spi_error_burst_reset_regs_tb;
    localparam int LIMIT = 40000;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic [15:0] cmd_word = 16'h0000;
    logic crc_on = 1'b0;
    logic keep_cs = 1'b0;
    logic cmd_ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic [3:0] sw_en;
    logic [7:0] flag_state;
    logic burst_active;
    logic [3:0] sw2;
    logic [7:0] flag2;
    logic [7:0] rsp;
    int failures = 0;
    int n_compared = 0;
    int cyc = 0;

    spi_link_if link();
    spi_link_if link2();

    always #5 sys_clk = ~sys_clk;

    spi_reg_dev i_spi_reg_dev (.sys_clk(sys_clk), .rst_n(rst_n), .link(link), .sw_en(sw_en),
        .flag_state(flag_state), .burst_active(burst_active));
    // Second device, driven bit by bit to send frames the host end never makes.
    spi_reg_dev i_spi_reg_dev_2 (.sys_clk(sys_clk), .rst_n(rst_n), .link(link2), .sw_en(sw2),
        .flag_state(flag2), .burst_active());
    spi_reg_host i_spi_reg_host (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
        .cmd_valid(cmd_valid), .cmd_word(cmd_word), .crc_on(crc_on), .keep_cs(keep_cs),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    spi_error_burst_reset_regs_monitor i_mon (.sys_clk(sys_clk), .rst_n(rst_n),
        .cs_n(link.cs_n), .sclk(link.sclk), .sdi(link.sdi), .flag_state(flag_state),
        .burst_active(burst_active));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    // The watchdog below bounds every wait on the host handshake.
    task automatic cmd(input logic [15:0] w, input logic crc, input logic keep);
        @(negedge sys_clk);
        while (cmd_ready !== 1'b1) @(negedge sys_clk);
        cmd_word = w;
        crc_on = crc;
        keep_cs = keep;
        cmd_valid = 1'b1;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1) @(negedge sys_clk);
        rsp = rsp_data;
        if (!keep) while (cmd_ready !== 1'b1) @(negedge sys_clk);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        cmd({1'b0, a, d}, 1'b0, 1'b0);
    endtask

    task automatic rd(input logic [6:0] a);
        cmd({1'b1, a, 8'h00}, 1'b0, 1'b0);
    endtask

    function automatic logic [7:0] crc_ref(input logic [15:0] w);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction

    // Sends the low n bits MSB first; the released data line is inverted so it shows no value.
    task automatic bang(input logic [23:0] bits, input int n);
        link2.cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            link2.sdi = bits[i];
            repeat (8) @(negedge sys_clk);
            link2.sclk = 1'b1;
            repeat (8) @(negedge sys_clk);
            link2.sclk = 1'b0;
        end
        repeat (8) @(negedge sys_clk);
        link2.cs_n = 1'b1;
        link2.sdi = ~link2.sdi;
        repeat (30) @(negedge sys_clk);
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            failures = failures + 1;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        link2.cs_n = 1'b1;
        link2.sclk = 1'b0;
        link2.sdi = 1'b0;
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        rd(spi_regs_pkg::ADDR_FLAGS);
        chk("flags reset", 8'h00, rsp);
        rd(spi_regs_pkg::ADDR_BURST);
        chk("burst reset", 8'h00, rsp);
        rd(spi_regs_pkg::ADDR_CFG);
        chk("config reset", 8'h06, rsp);
        rd(spi_regs_pkg::ADDR_KEY);
        chk("key read", 8'h00, rsp);
        rd(7'h04);
        chk("bad read flag", 8'h04, flag_state);
        rd(spi_regs_pkg::ADDR_FLAGS);
        chk("flags read", 8'h04, rsp);
        cmd(spi_regs_pkg::CLEAR_CMD, 1'b0, 1'b0);
        chk("clear", 8'h00, flag_state);
        wr(spi_regs_pkg::ADDR_FLAGS, 8'h07);
        chk("read-only write flag", 8'h04, flag_state);
        wr(spi_regs_pkg::ADDR_SW, 8'h05);
        chk("switch write", 8'h05, {4'h0, sw_en});
        chk("flag kept", 8'h04, flag_state);
        cmd({1'b0, spi_regs_pkg::ADDR_SW, 8'h0A}, 1'b1, 1'b0);
        chk("long frame flag", 8'h06, flag_state);
        chk("long frame ignored", 8'h05, {4'h0, sw_en});
        cmd(spi_regs_pkg::CLEAR_CMD, 1'b0, 1'b0);
        chk("clear both", 8'h00, flag_state);
        wr(spi_regs_pkg::ADDR_BURST, 8'h01);
        chk("burst on", 8'h01, {7'h00, burst_active});
        cmd({1'b0, spi_regs_pkg::ADDR_SW, 8'h03}, 1'b0, 1'b1);
        cmd({1'b1, spi_regs_pkg::ADDR_BURST, 8'h00}, 1'b0, 1'b0);
        chk("burst read", 8'h01, rsp);
        chk("burst write", 8'h03, {4'h0, sw_en});
        chk("burst no flag", 8'h00, flag_state);
        wr(spi_regs_pkg::ADDR_BURST, 8'h00);
        cmd({1'b0, spi_regs_pkg::ADDR_SW, 8'h0C}, 1'b0, 1'b1);
        cmd({1'b0, spi_regs_pkg::ADDR_SW, 8'h0C}, 1'b0, 1'b0);
        chk("double frame flag", 8'h02, flag_state);
        chk("double frame ignored", 8'h03, {4'h0, sw_en});
        cmd(spi_regs_pkg::CLEAR_CMD, 1'b0, 1'b0);
        wr(spi_regs_pkg::ADDR_CFG, 8'h02);
        rd(7'h04);
        chk("address check off", 8'h00, flag_state);
        wr(spi_regs_pkg::ADDR_CFG, 8'h07);
        cmd({1'b1, 7'h04, 8'h00}, 1'b1, 1'b0);
        chk("crc bad read flag", 8'h04, flag_state);
        cmd(spi_regs_pkg::CLEAR_CMD, 1'b1, 1'b0);
        chk("crc clear", 8'h00, flag_state);
        cmd({1'b0, spi_regs_pkg::ADDR_CFG, 8'h02}, 1'b1, 1'b0);
        wr(spi_regs_pkg::ADDR_SW, 8'h0F);
        wr(spi_regs_pkg::ADDR_BURST, 8'h01);
        wr(spi_regs_pkg::ADDR_KEY, spi_regs_pkg::KEY_FIRST);
        wr(spi_regs_pkg::ADDR_SW, 8'h0F);
        wr(spi_regs_pkg::ADDR_KEY, spi_regs_pkg::KEY_SECOND);
        chk("broken key", 8'h0F, {4'h0, sw_en});
        wr(spi_regs_pkg::ADDR_KEY, spi_regs_pkg::KEY_FIRST);
        wr(spi_regs_pkg::ADDR_KEY, spi_regs_pkg::KEY_SECOND);
        chk("soft reset switch", 8'h00, {4'h0, sw_en});
        chk("soft reset burst", 8'h00, {7'h00, burst_active});
        rd(spi_regs_pkg::ADDR_CFG);
        chk("soft reset config", 8'h06, rsp);
        bang({8'h00, 16'h0207}, 16);
        bang({16'h0105, crc_ref(16'h0105)}, 24);
        chk("good crc write", 8'h05, {4'h0, sw2});
        bang({16'h010A, crc_ref(16'h010A) ^ 8'hFF}, 24);
        chk("bad crc flag", 8'h01, flag2);
        chk("bad crc ignored", 8'h05, {4'h0, sw2});
        // A second flag is raised so that a wrongly obeyed clear would show.
        bang({16'h0307, crc_ref(16'h0307)}, 24);
        chk("read-only crc write flag", 8'h05, flag2);
        bang({spi_regs_pkg::CLEAR_CMD, crc_ref(spi_regs_pkg::CLEAR_CMD) ^ 8'h5A}, 24);
        chk("bad crc clear", 8'h05, flag2);
        bang({spi_regs_pkg::CLEAR_CMD, crc_ref(spi_regs_pkg::CLEAR_CMD)}, 24);
        chk("good crc clear", 8'h00, flag2);
        summarize();
    end
endmodule // spi_error_burst_reset_regs_tb
